// ---- core/tsec_top.sv ----
// top: routing stage, core event stage and apb register slave
// Contract
// - ids 0-2 to 7, 3-4 to 8, 5-8 to 9
// - ids 9-14 default to level 10
// - ids 15-18 default to level 11
// - ids 19-28 default to level 12
// - ids 29-31 default to level 13
// - core latch, mask, pending registers, 16 bits
// - latch set/cleared by hardware; writes need mask clear
// - set mask bit allows service, clear blocks
// - mask and pending accessible only in supervisor
// - global enable and disable instructions
// - pending bit set while event active or nested
// - routing mask, status, wakeup registers, 32 bits
// - set routing mask passes peripheral event
// - status bit mirrors peripheral request level
// - enabled wakeup event wakes idle core
// - pending bits serve as routing acknowledgement; the routing stage here never reads them
// - rising edge sets latch, two cycles detection
// - latch clears when pending sets; next edge queued
// - edge to pending takes at least three cycles
// - levels 7-15, lower number higher priority
// - software can reassign each id's level
`timescale 1ns/1ps
module tsec_top (
  input wire logic pclk,
  input wire logic presetn,
  input wire tsec_pkg::tsec_apb_req_t apb_req,
  output tsec_pkg::tsec_apb_rsp_t apb_rsp,
  input wire logic [tsec_pkg::NUM_IDS-1:0] periph_irq,
  input wire logic [1:0] soft_level_req,
  input wire logic global_irq_on_instr,
  input wire logic global_irq_off_instr,
  input wire logic core_idle,
  input wire tsec_pkg::tsec_pipe_t pipe,
  output logic [tsec_pkg::LVL_W-1:0] service_level,
  output logic service_req,
  output logic [tsec_pkg::NUM_EVT-1:0] core_event_pending,
  output logic wake_req
);
  import tsec_pkg::*;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_ARMED
  } tsec_dispatch_t;

  function automatic logic [LVL_W-1:0] id_level(input logic [127:0] map, input int id);
    id_level = map[id*LVL_W +: LVL_W];
  endfunction : id_level

  logic [127:0] assign_q;
  logic [NUM_IDS-1:0] pmask_q;
  logic [NUM_IDS-1:0] pwake_q;
  logic [NUM_IDS-1:0] pstat_q;
  logic [NUM_EVT-1:0] latch_q;
  logic [NUM_EVT-1:0] mask_q;
  logic [NUM_EVT-1:0] pend_q;
  logic [NUM_EVT-1:0] sync1_q;
  logic [NUM_EVT-1:0] sync2_q;
  logic [NUM_EVT-1:0] prev_q;
  logic [NUM_EVT-1:0] gp_in;
  logic [NUM_EVT-1:0] edge_det;
  logic [NUM_EVT-1:0] pend_set;
  logic [NUM_EVT-1:0] pend_clr;
  logic [NUM_EVT-1:0] ready_evt;
  logic [NUM_EVT-1:0] busy;
  logic gie_q;
  logic super_q;
  logic wake_q;
  logic [LVL_W-1:0] svc_lvl_q;
  logic svc_req_q;
  logic [31:0] prdata_q;
  logic pslverr_q;
  tsec_dispatch_t disp_q;

  logic acc;
  logic wr;
  logic rd;
  logic [11:0] addr;
  assign acc = apb_req.psel && apb_req.penable;
  assign wr = acc && apb_req.pwrite;
  assign rd = acc && !apb_req.pwrite;
  assign addr = apb_req.paddr;

  // routing: or of unmasked requests per assigned level
  always_comb begin
    gp_in = '0;
    for (int i = 0; i < NUM_IDS; i++) begin
      if (periph_irq[i] && pmask_q[i]) begin
        gp_in[id_level(assign_q, i)] = 1'b1;
      end
    end
    gp_in[GP_HI-1] = gp_in[GP_HI-1] | soft_level_req[0];
    gp_in[GP_HI] = gp_in[GP_HI] | soft_level_req[1];
    for (int l = 0; l < GP_LO; l++) begin
      gp_in[l] = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pstat_q <= '0;
    end else begin
      pstat_q <= periph_irq;
    end
  end

  // wake only while the core sits idle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wake_q <= 1'b0;
    end else begin
      wake_q <= core_idle && |(periph_irq & pwake_q);
    end
  end

  // two-flop edge detection on each level input
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_q <= '0;
      sync2_q <= '0;
      prev_q <= '0;
    end else begin
      sync1_q <= gp_in;
      sync2_q <= sync1_q;
      prev_q <= sync2_q;
    end
  end
  assign edge_det = sync2_q & ~prev_q;

  // pipeline reports entry and return of a level
  always_comb begin
    pend_set = '0;
    pend_clr = '0;
    if (pipe.enter) begin
      pend_set[pipe.level] = 1'b1;
    end
    if (pipe.ret) begin
      pend_clr[pipe.level] = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pend_q <= '0;
    end else begin
      // entering wins over a return in the same cycle
      pend_q <= (pend_q & ~pend_clr) | pend_set;
    end
  end

  // latch: a new edge wins over both clears, so no event is lost
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      latch_q <= LATCH_RST;
    end else begin
      for (int e = 0; e < NUM_EVT; e++) begin
        if (edge_det[e]) begin
          latch_q[e] <= 1'b1;
        end else if (pend_set[e]) begin
          latch_q[e] <= 1'b0;
        end else if (wr && addr == OFF_LATCH && !mask_q[e]) begin
          latch_q[e] <= apb_req.pwdata[e];
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mask_q <= MASK_RST;
    end else if (wr && addr == OFF_MASK && super_q) begin
      mask_q <= apb_req.pwdata[NUM_EVT-1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gie_q <= 1'b0;
      super_q <= 1'b1;
    end else begin
      if (global_irq_on_instr) begin
        gie_q <= 1'b1;
      end else if (global_irq_off_instr) begin
        gie_q <= 1'b0;
      end else if (wr && addr == OFF_CTRL) begin
        gie_q <= apb_req.pwdata[CTRL_GIE_BIT];
      end
      if (wr && addr == OFF_CTRL) begin
        super_q <= apb_req.pwdata[CTRL_SUPER_BIT];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pmask_q <= PMASK_RST;
      pwake_q <= PWAKE_RST;
    end else begin
      if (wr && addr == OFF_PMASK) begin
        pmask_q <= apb_req.pwdata;
      end
      if (wr && addr == OFF_PWAKE) begin
        pwake_q <= apb_req.pwdata;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      assign_q <= ASSIGN_RST;
    end else begin
      for (int r = 0; r < ASSIGN_REGS; r++) begin
        if (wr && addr == OFF_ASSIGN0 + 12'(4 * r)) begin
          assign_q[r*32 +: 32] <= apb_req.pwdata;
        end
      end
    end
  end

  // an event entering this cycle already counts as active, so it is not offered again once it enters
  assign busy = pend_q | pend_set;

  // highest-priority ready event: lowest number, only above any active one
  always_comb begin
    ready_evt = latch_q & mask_q;
    if (!gie_q) begin
      ready_evt = '0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      svc_lvl_q <= '0;
      svc_req_q <= 1'b0;
      disp_q <= ST_IDLE;
    end else begin
      svc_req_q <= 1'b0;
      case (disp_q)
        ST_IDLE: begin
          for (int e = GP_HI; e >= GP_LO; e--) begin
            if (ready_evt[e] && !busy[e] && (busy & ((16'h0001 << e) - 16'h0001)) == '0) begin
              svc_lvl_q <= LVL_W'(e);
              svc_req_q <= 1'b1;
            end
          end
          if (|ready_evt) begin
            disp_q <= ST_ARMED;
          end
        end
        ST_ARMED: begin
          // the request is a one-cycle offer; re-offer after a short gap
          disp_q <= ST_IDLE;
        end
        default: begin
          disp_q <= ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= '0;
      pslverr_q <= 1'b0;
    end else if (apb_req.psel && !apb_req.penable) begin
      pslverr_q <= 1'b0;
      prdata_q <= '0;
      case (addr)
        OFF_LATCH: prdata_q <= {16'h0000, latch_q};
        OFF_MASK: begin
          if (super_q) begin
            prdata_q <= {16'h0000, mask_q};
          end else begin
            pslverr_q <= 1'b1;
          end
        end
        OFF_PEND: begin
          if (super_q) begin
            prdata_q <= {16'h0000, pend_q};
          end else begin
            pslverr_q <= 1'b1;
          end
        end
        OFF_PMASK: prdata_q <= pmask_q;
        OFF_PSTAT: prdata_q <= pstat_q;
        OFF_PWAKE: prdata_q <= pwake_q;
        OFF_CTRL: prdata_q <= {30'h00000000, super_q, gie_q};
        default: begin
          if (addr >= OFF_ASSIGN0 && addr <= OFF_ASSIGN3 && addr[1:0] == 2'h0) begin
            prdata_q <= assign_q[addr[3:2]*32 +: 32];
          end else begin
            pslverr_q <= 1'b1;
          end
        end
      endcase
    end
  end

  assign apb_rsp = '{pready: 1'b1, pslverr: acc && pslverr_q, prdata: prdata_q};
  assign service_level = svc_lvl_q;
  assign service_req = svc_req_q;
  assign core_event_pending = pend_q;
  assign wake_req = wake_q;
endmodule : tsec_top

// ---- inc/tsec_pkg.sv ----
// package: register map, field layouts and defaults of the two-stage event controller
package tsec_pkg;
  localparam int NUM_IDS = 32;
  localparam int NUM_EVT = 16;
  localparam int LVL_W = 4;
  localparam int GP_LO = 7;
  localparam int GP_HI = 15;
  localparam int SYNC_STAGES = 2;

  // byte addresses of the registers
  localparam logic [11:0] OFF_LATCH = 12'h000;
  localparam logic [11:0] OFF_MASK = 12'h004;
  localparam logic [11:0] OFF_PEND = 12'h008;
  localparam logic [11:0] OFF_PMASK = 12'h00c;
  localparam logic [11:0] OFF_PSTAT = 12'h010;
  localparam logic [11:0] OFF_PWAKE = 12'h014;
  localparam logic [11:0] OFF_CTRL = 12'h018;
  localparam logic [11:0] OFF_ASSIGN0 = 12'h020;
  localparam logic [11:0] OFF_ASSIGN3 = 12'h02c;
  localparam int ASSIGN_REGS = 4;
  localparam int IDS_PER_ASSIGN = 8;

  localparam int CTRL_GIE_BIT = 0;
  localparam int CTRL_SUPER_BIT = 1;

  localparam logic [15:0] LATCH_RST = 16'h0000;
  localparam logic [15:0] MASK_RST = 16'h0000;
  localparam logic [31:0] PMASK_RST = 32'h00000000;
  localparam logic [31:0] PWAKE_RST = 32'h00000000;

  // default level per ID, four bits each, ID 0 in the low nibble
  localparam logic [127:0] ASSIGN_RST = {
    4'hd, 4'hd, 4'hd,
    4'hc, 4'hc, 4'hc, 4'hc, 4'hc, 4'hc, 4'hc, 4'hc, 4'hc, 4'hc,
    4'hb, 4'hb, 4'hb, 4'hb,
    4'ha, 4'ha, 4'ha, 4'ha, 4'ha, 4'ha,
    4'h9, 4'h9, 4'h9, 4'h9,
    4'h8, 4'h8,
    4'h7, 4'h7, 4'h7};

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } tsec_apb_req_t;

  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } tsec_apb_rsp_t;

  // pipeline side: enter/return strobes for one level
  typedef struct packed {
    logic enter;
    logic ret;
    logic [LVL_W-1:0] level;
  } tsec_pipe_t;
endpackage : tsec_pkg

// ---- tb/tsec_pipe_model.sv ----
// pipeline model: enters offered levels, returns on command
`timescale 1ns/1ps
module tsec_pipe_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic service_req,
  input wire logic [tsec_pkg::LVL_W-1:0] service_level,
  input wire logic stall,
  input wire logic ret_go,
  input wire logic [tsec_pkg::LVL_W-1:0] ret_lvl,
  output tsec_pkg::tsec_pipe_t pipe
);
  import tsec_pkg::*;
  // stall holds off entry so that re-offers can be seen
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pipe <= '0;
    end else begin
      // one level field: a return in this cycle defers entry to the next offer
      pipe.enter <= service_req && !stall && !ret_go;
      pipe.ret <= ret_go;
      pipe.level <= ret_go ? ret_lvl : service_level;
    end
  end
endmodule : tsec_pipe_model

// ---- tb/tsec_top_assertions.sv ----
// checker: port relations of the event controller
`timescale 1ns/1ps
module tsec_top_assertions (
  input wire logic pclk,
  input wire logic presetn,
  input wire tsec_pkg::tsec_apb_req_t apb_req,
  input wire tsec_pkg::tsec_apb_rsp_t apb_rsp,
  input wire logic global_irq_on_instr,
  input wire logic global_irq_off_instr,
  input wire logic core_idle,
  input wire tsec_pkg::tsec_pipe_t pipe,
  input wire logic [tsec_pkg::LVL_W-1:0] service_level,
  input wire logic service_req,
  input wire logic [tsec_pkg::NUM_EVT-1:0] core_event_pending,
  input wire logic wake_req
);
  import tsec_pkg::*;
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  sequence gie_off_s;
    global_irq_off_instr && !global_irq_on_instr ##1 !global_irq_on_instr [*2];
  endsequence
  err_access_a: assert property (apb_rsp.pslverr |-> apb_req.psel && apb_req.penable)
    else $error("error outside access");
  gie_off_a: assert property (gie_off_s |-> !service_req)
    else $error("offer while disabled");
  offer_pulse_a: assert property (service_req |=> !service_req)
    else $error("offer too long");
  offer_level_a: assert property (service_req |-> service_level >= GP_LO)
    else $error("offer level low");
  low_unused_a: assert property (core_event_pending[6:0] == 7'h00)
    else $error("low pending set");
  enter_pend_a: assert property (pipe.enter |=> core_event_pending[$past(pipe.level)])
    else $error("pending not set");
  ret_clear_a: assert property (pipe.ret && !pipe.enter |=>
    !core_event_pending[$past(pipe.level)]) else $error("pending not cleared");
  wake_idle_a: assert property (wake_req |-> $past(core_idle))
    else $error("wake while busy");
endmodule : tsec_top_assertions

// ---- tb/test_two_stage_event_controller.sv ----
// testbench: register map and event flow checks
`timescale 1ns/1ps
module test_two_stage_event_controller;
  import tsec_pkg::*;
  logic pclk, presetn, g_on, g_off, idle, stall, ret_go, svc, wake, err;
  tsec_apb_req_t req;
  tsec_apb_rsp_t rsp;
  tsec_pipe_t pipe;
  logic [31:0] irq, rd, ex;
  logic [3:0] lvl, ret_lvl, lv;
  logic [15:0] pend;
  logic [11:0] zr [4] = '{OFF_LATCH, OFF_MASK, OFF_PMASK, OFF_PWAKE};
  int failures, checks, cyc, hits, first;
  tsec_top DUT (.pclk(pclk), .presetn(presetn), .apb_req(req), .apb_rsp(rsp),
    .periph_irq(irq), .soft_level_req(2'b00), .global_irq_on_instr(g_on),
    .global_irq_off_instr(g_off), .core_idle(idle), .pipe(pipe), .service_level(lvl),
    .service_req(svc), .core_event_pending(pend), .wake_req(wake));
  tsec_pipe_model u_pipe (.pclk(pclk), .presetn(presetn), .service_req(svc),
    .service_level(lvl), .stall(stall), .ret_go(ret_go), .ret_lvl(ret_lvl), .pipe(pipe));
  initial begin
    pclk = 0;
    forever #10 pclk = ~pclk;
  end
  task wrap_up;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : wrap_up
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 3000) begin
      failures++;
      wrap_up();
    end
  end
  task chk(input logic [31:0] s, input logic [31:0] e, input string m);
    checks++;
    if (s !== e) begin
      failures++;
      $display("unexpected %0t %s: %h vs %h", $time, m, s, e);
    end
  endtask : chk
  // request held until the edge that sees pready
  task xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    req <= '{1'b1, 1'b0, w, a, d};
    @(posedge pclk);
    req.penable <= 1'b1;
    @(posedge pclk);
    while (rsp.pready !== 1'b1) @(posedge pclk);
    rd = rsp.prdata;
    err = rsp.pslverr;
    req <= '0;
  endtask : xfer
  task watch(input int c);
    hits = 0;
    first = 99;
    for (int i = 1; i <= c; i++) begin
      @(posedge pclk);
      if (svc === 1'b1) begin
        if (hits == 0) first = i;
        if (hits == 0) lv = lvl;
        hits++;
      end
    end
  endtask : watch
  task ret(input logic [3:0] l);
    ret_lvl <= l;
    ret_go <= 1;
    @(posedge pclk);
    ret_go <= 0;
  endtask : ret
  function automatic logic [3:0] dflt(input int id);
    return id < 3 ? 4'h7 : id < 5 ? 4'h8 : id < 9 ? 4'h9 : id < 15 ? 4'ha :
      id < 19 ? 4'hb : id < 29 ? 4'hc : 4'hd;
  endfunction : dflt
  initial begin
    presetn = 0;
    req = '0;
    irq = '0;
    g_on = 0;
    g_off = 0;
    idle = 0;
    stall = 1;
    ret_go = 0;
    ret_lvl = 0;
    repeat (10) @(posedge pclk);
    presetn <= 1;
    for (int i = 0; i < 4; i++) begin
      xfer(0, zr[i], 0);
      chk(rd, 0, "reset");
    end
    for (int w = 0; w < 4; w++) begin
      for (int b = 0; b < 8; b++) ex[b*4 +: 4] = dflt(w * 8 + b);
      xfer(0, OFF_ASSIGN0 + 12'(w * 4), 0);
      chk(rd, ex, "map");
    end
    xfer(1, OFF_PEND, 32'hffff);
    xfer(0, OFF_PEND, 0);
    chk(rd, 0, "pend ro");
    xfer(0, 12'h100, 0);
    chk(err, 1, "unmapped");
    xfer(1, OFF_CTRL, 32'h3);
    xfer(1, OFF_PMASK, 32'h8);
    xfer(1, OFF_MASK, 32'h100);
    irq[3] <= 1;
    watch(10);
    chk(lv, 8, "level");
    chk(first >= 3, 1, "latency");
    chk(hits > 1, 1, "reoffer");
    chk(pend[8], 0, "early pend");
    stall <= 0;
    repeat (6) @(posedge pclk);
    chk(pend[8], 1, "pend");
    xfer(0, OFF_PSTAT, 0);
    chk(rd, 32'h8, "status");
    xfer(0, OFF_LATCH, 0);
    chk(rd, 0, "latch clr");
    idle <= 1;
    xfer(1, OFF_PWAKE, 32'h8);
    repeat (2) @(posedge pclk);
    chk(wake, 1, "wake");
    idle <= 0;
    repeat (2) @(posedge pclk);
    chk(wake, 0, "busy no wake");
    irq[3] <= 0;
    repeat (2) @(posedge pclk);
    irq[3] <= 1;
    repeat (2) @(posedge pclk);
    xfer(0, OFF_LATCH, 0);
    chk(rd, 32'h100, "queued");
    ret(8);
    repeat (8) @(posedge pclk);
    xfer(0, OFF_LATCH, 0);
    chk(rd, 0, "requeue");
    ret(8);
    xfer(1, OFF_PMASK, 32'h20);
    irq[9] <= 1;
    irq[5] <= 1;
    watch(8);
    chk(hits, 0, "core mask");
    xfer(0, OFF_LATCH, 0);
    chk(rd, 32'h200, "sys mask");
    xfer(1, OFF_LATCH, 32'h500);
    xfer(0, OFF_LATCH, 0);
    chk(rd, 32'h400, "latch wr");
    xfer(1, OFF_LATCH, 0);
    xfer(1, OFF_ASSIGN0, 32'h9998877a);
    xfer(1, OFF_PMASK, 32'h1);
    irq[0] <= 1;
    repeat (5) @(posedge pclk);
    xfer(0, OFF_LATCH, 0);
    chk(rd, 32'h400, "remap");
    xfer(1, OFF_LATCH, 32'h600);
    g_off <= 1;
    @(posedge pclk);
    g_off <= 0;
    xfer(1, OFF_MASK, 32'h600);
    watch(8);
    chk(hits, 0, "gie off");
    g_on <= 1;
    @(posedge pclk);
    g_on <= 0;
    watch(6);
    chk(lv, 9, "gie on");
    repeat (4) @(posedge pclk);
    ret(9);
    watch(6);
    chk(lv, 10, "next level");
    xfer(1, OFF_CTRL, 0);
    xfer(0, OFF_MASK, 0);
    chk(err, 1, "user mode");
    wrap_up();
  end
endmodule : test_two_stage_event_controller
bind tsec_top tsec_top_assertions u_chk (.pclk(pclk), .presetn(presetn),
  .apb_req(apb_req), .apb_rsp(apb_rsp), .global_irq_on_instr(global_irq_on_instr),
  .global_irq_off_instr(global_irq_off_instr), .core_idle(core_idle), .pipe(pipe),
  .service_level(service_level), .service_req(service_req),
  .core_event_pending(core_event_pending), .wake_req(wake_req));
